// file: fsrc_top.sv
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fsrc_top
    import fsrc_pkg::*;
#(
    parameter int WRITE_TICKS = WRITE_MIN_TICKS
)(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        por_n,
    input  wire logic        rc_osc,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        load_req,
    input  wire logic        store_req,
    input  wire logic [15:0] z_index,
    input  wire logic [7:0]  store_data,
    output logic      [15:0] pm_addr,
    input  wire logic [7:0]  pm_data,
    output fsrc_load_t       load_result,
    input  wire logic [7:0]  fuse_low_value,
    input  wire logic [7:0]  fuse_high_value,
    input  wire logic [7:0]  fuse_extended_value,
    output logic             flash_busy
);
    localparam int TW = $clog2(WRITE_TICKS + 1);
    localparam logic [TW-1:0] LAST_TICK = TW'(WRITE_TICKS - 1);

    // ======================================================
    // reset release and oscillator sync
    logic       rst_s1;
    logic       rst_core_n;
    logic       por_s1;
    logic       por_core_n;
    logic       rc_s1;
    logic       rc_s2;
    logic       rc_s3;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1     <= 1'b0;
            rst_core_n <= 1'b0;
        end
        else
        begin
            rst_s1     <= 1'b1;
            rst_core_n <= rst_s1;
        end
    end

    // writer has its own reset so a core reset leaves it running
    always_ff @(posedge clock or negedge por_n)
    begin
        if (!por_n)
        begin
            por_s1     <= 1'b0;
            por_core_n <= 1'b0;
        end
        else
        begin
            por_s1     <= 1'b1;
            por_core_n <= por_s1;
        end
    end

    always_ff @(posedge clock or negedge por_core_n)
    begin
        if (!por_core_n)
        begin
            rc_s1 <= 1'b0;
            rc_s2 <= 1'b0;
            rc_s3 <= 1'b0;
        end
        else
        begin
            rc_s1 <= rc_osc;
            rc_s2 <= rc_s1;
            rc_s3 <= rc_s2;
        end
    end

    wire rc_rise = rc_s2 & ~rc_s3;

    // ======================================================
    // state
    fsrc_ctrl_t   ctrl;
    logic [2:0]   win_cnt;
    fsrc_wstate_t wstate;
    logic [TW-1:0] tick_cnt;
    logic         lock_op;
    logic [7:0]   lock_data;
    logic [3:0]   lock_prog;
    logic         pm_pending;

    // ======================================================
    // decode
    wire apb_setup = psel & ~penable;
    wire apb_done  = psel & penable & pready;
    wire hit_ctrl  = (paddr == ADDR_CTRL);
    wire hit_stat  = (paddr == ADDR_STAT);
    wire hit_load  = (paddr == ADDR_LOAD);
    wire hit_lock  = (paddr == ADDR_LOCK);
    wire hit_any   = hit_ctrl | hit_stat | hit_load | hit_lock;
    wire busy      = (wstate == FW_WRITE);
    // control writes refused while flash is busy
    wire ctrl_wr   = apb_done & pwrite & hit_ctrl & ~busy;
    wire both_set  = ctrl.read_select & ctrl.enable;
    wire load_open = both_set & (win_cnt < LOAD_WIN);
    wire rd_fuse   = load_req & load_open;
    wire store_go  = store_req & ctrl.enable & ~busy
                     & (win_cnt < STORE_WIN);
    wire win_end   = ctrl.enable & (win_cnt == STORE_WIN - 3'h1);
    wire wr_done   = busy & rc_rise & (tick_cnt == LAST_TICK);
    wire [7:0] lock_rb = {2'b11, ~lock_prog, 2'b11};

    // masks are 1 for programmed; every source is an argument so the wire follows it
    function automatic logic [7:0] fuse_sel(input logic [15:0] idx,
        input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] ex, input logic [7:0] lk);
        if (idx == IDX_FUSE_LOW)
            return ~lo;
        else if (idx == IDX_FUSE_HIGH)
            return ~hi;
        else if (idx == IDX_FUSE_EXT)
            return ~ex;
        else if (idx == IDX_LOCK)
            return lk;
        else
            return 8'hFF;
    endfunction

    wire [7:0] fuse_byte =
        fuse_sel(z_index, fuse_low_value, fuse_high_value, fuse_extended_value, lock_rb);

    wire [31:0] rd_mux =
        hit_ctrl ? {28'h0, ctrl} :
        hit_stat ? {28'h0, win_cnt, busy} :
        hit_load ? {24'h0, load_result.data} :
        hit_lock ? {24'h0, lock_rb} : 32'h0;

    // ======================================================
    // apb slave: one wait-free access phase
    always_ff @(posedge clock or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= apb_setup;
            prdata  <= apb_setup & ~pwrite ? rd_mux : 32'h0;
            pslverr <= apb_setup & ~hit_any;
        end
    end

    // ======================================================
    // control bits and cycle window
    always_ff @(posedge clock or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            ctrl    <= CTRL_RESET;
            win_cnt <= 3'h0;
        end
        else if (ctrl_wr)
        begin
            ctrl    <= pwdata[3:0];
            win_cnt <= 3'h0;
        end
        else if (rd_fuse | store_go | win_end)
        begin
            ctrl    <= CTRL_RESET;
            win_cnt <= 3'h0;
        end
        else if (ctrl.enable)
            win_cnt <= win_cnt + 3'h1;
    end

    // ======================================================
    // load path
    always_ff @(posedge clock or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            pm_addr     <= 16'h0;
            pm_pending  <= 1'b0;
            load_result <= '0;
        end
        else
        begin
            pm_pending <= load_req & ~rd_fuse;
            if (load_req & ~rd_fuse)
                pm_addr <= z_index;
            if (rd_fuse)
                load_result <= {fuse_byte, 1'b1};
            else if (pm_pending)
                load_result <= {pm_data, 1'b1};
            else
                load_result.valid <= 1'b0;
        end
    end

    // ======================================================
    // flash writer on supply reset only
    always_ff @(posedge clock or negedge por_core_n)
    begin
        if (!por_core_n)
        begin
            wstate    <= FW_IDLE;
            tick_cnt  <= '0;
            lock_op   <= 1'b0;
            lock_data <= 8'hFF;
            lock_prog <= LOCK_PROG_RESET;
            flash_busy <= 1'b0;
        end
        else
        begin
            case (wstate)
                FW_IDLE:
                begin
                    // store_go is low under core reset: ctrl is clear
                    if (store_go)
                    begin
                        wstate     <= FW_WRITE;
                        tick_cnt   <= '0;
                        lock_op    <= ctrl.read_select;
                        lock_data  <= store_data;
                        flash_busy <= 1'b1;
                    end
                end
                FW_WRITE:
                begin
                    if (wr_done)
                    begin
                        wstate     <= FW_IDLE;
                        flash_busy <= 1'b0;
                        if (lock_op)
                            lock_prog <= lock_prog | ~lock_data[5:2];
                    end
                    else if (rc_rise)
                        tick_cnt <= tick_cnt + TW'(1);
                end
                default:
                    wstate <= FW_IDLE;
            endcase
        end
    end

    // ======================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_core_n);

    a_window_expire: assert property (
        win_end & ~store_go & ~ctrl_wr |=> !ctrl.enable && !ctrl.read_select)
        else $error("control bits survived window");

    a_ordinary_load: assert property (
        load_req & ~ctrl.enable & ~ctrl.read_select
        |=> pm_addr == $past(z_index) ##1 load_result.valid
            && load_result.data == $past(pm_data))
        else $error("ordinary load not returned");

    a_low_fuse: assert property (
        rd_fuse && z_index == IDX_FUSE_LOW
        |=> load_result.valid && load_result.data == ~$past(fuse_low_value))
        else $error("low fuse readback wrong");

    a_high_fuse: assert property (
        rd_fuse && z_index == IDX_FUSE_HIGH
        |=> load_result.data == ~$past(fuse_high_value))
        else $error("high fuse readback wrong");

    a_ext_fuse: assert property (
        rd_fuse && z_index == IDX_FUSE_EXT
        |=> load_result.data == ~$past(fuse_extended_value))
        else $error("extended fuse readback wrong");

    a_lock_read: assert property (
        rd_fuse && z_index == IDX_LOCK
        |=> load_result.data[5:2] == ~$past(lock_prog)
            && load_result.data[1:0] == 2'b11)
        else $error("lock readback wrong");

    a_read_polarity: assert property (
        rd_fuse && z_index == IDX_FUSE_HIGH
        |=> (load_result.data & $past(fuse_high_value)) == 8'h00)
        else $error("programmed bits not read as zero");

    a_read_clears: assert property (
        rd_fuse & ~ctrl_wr |=> !ctrl.enable ##1 !load_result.valid)
        else $error("control bits kept after readback");

    a_rc_timed: assert property (
        busy & ~rc_rise & ~wr_done |=> tick_cnt == $past(tick_cnt))
        else $error("write advanced without rc tick");

    a_write_length: assert property (
        // shortened writes are allowed for simulation, never longer than max
        $fell(flash_busy) |-> $past(tick_cnt) == LAST_TICK
            && WRITE_TICKS * RC_PERIOD_NS <= WRITE_MAX_NS)
        else $error("flash write length wrong");

    a_reset_keeps: assert property (
        @(posedge clock) disable iff (!por_core_n)
        busy & ~wr_done |=> flash_busy)
        else $error("write aborted");

    c_fuse_read: cover property (rd_fuse ##1 load_result.valid);
    c_ordinary: cover property (load_req & ~load_open ##2 load_result.valid);
    c_write_done: cover property ($fell(flash_busy));
    c_expire: cover property (win_end & ~store_go);
endmodule // fsrc_top
`default_nettype wire

// file: fsrc_pkg.sv
`default_nettype none
package fsrc_pkg;
    // ======================================================
    // register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_LOAD = 8'h08;
    localparam logic [7:0] ADDR_LOCK = 8'h0C;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [3:0] LOCK_PROG_RESET = 4'h0;
    // ======================================================
    // index pointer selectors
    localparam logic [15:0] IDX_FUSE_LOW  = 16'h0000;
    localparam logic [15:0] IDX_LOCK      = 16'h0001;
    localparam logic [15:0] IDX_FUSE_EXT  = 16'h0002;
    localparam logic [15:0] IDX_FUSE_HIGH = 16'h0003;
    // ======================================================
    // cycle windows and timing
    localparam logic [2:0] LOAD_WIN  = 3'h3;
    localparam logic [2:0] STORE_WIN = 3'h4;
    localparam int CLK_PERIOD_NS = 8;
    localparam int RC_PERIOD_NS  = 1000;
    localparam int WRITE_MIN_NS  = 3700000;
    localparam int WRITE_MAX_NS  = 4500000;
    localparam int WRITE_MIN_TICKS =
        (WRITE_MIN_NS + RC_PERIOD_NS - 1) / RC_PERIOD_NS;
    localparam int WRITE_MAX_TICKS = WRITE_MAX_NS / RC_PERIOD_NS;
    // ======================================================
    // types
    typedef struct packed {
        logic read_select;
        logic page_write;
        logic page_erase;
        logic enable;
    } fsrc_ctrl_t;
    typedef struct packed {
        logic [7:0] data;
        logic       valid;
    } fsrc_load_t;
    typedef enum {FW_IDLE, FW_WRITE} fsrc_wstate_t;
endpackage
`default_nettype wire

// file: fsrc_pmem_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsrc_pmem_model
    import fsrc_pkg::*;
(
    input  wire logic [15:0] pm_addr,
    output logic      [7:0]  pm_data,
    output logic             rc_osc
);
    // ==========================================
    // program memory, both address bytes folded in
    assign pm_data = pm_addr[7:0] ^ pm_addr[15:8] ^ 8'hA5;
    // ==========================================
    // calibrated oscillator, odd offset so it never lines up with clock
    initial
    begin
        rc_osc = 1'b0;
        #137;
        forever #(RC_PERIOD_NS / 2) rc_osc = ~rc_osc;
    end
endmodule // fsrc_pmem_model
`default_nettype wire

// file: fsrc_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fsrc_bench
    import fsrc_pkg::*;
;
    localparam int WT = 4;
    logic        clock, rst_n, por_n, rc_osc, psel, penable, pwrite;
    logic        pready, pslverr, er, load_req, store_req, flash_busy, rc_q;
    logic [7:0]  paddr, store_data, pm_data, f_lo, f_hi, f_ex, got, lock_rb;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [15:0] z_index, pm_addr;
    fsrc_load_t  load_result;
    int          error_cnt, cmp_count, ticks, n;

    fsrc_top #(.WRITE_TICKS(WT)) fsrc_top_i (.clock(clock), .rst_n(rst_n), .por_n(por_n),
        .rc_osc(rc_osc), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .load_req(load_req), .store_req(store_req), .z_index(z_index),
        .store_data(store_data), .pm_addr(pm_addr), .pm_data(pm_data),
        .load_result(load_result), .fuse_low_value(f_lo), .fuse_high_value(f_hi),
        .fuse_extended_value(f_ex), .flash_busy(flash_busy));
    fsrc_pmem_model fsrc_pmem_model_i (.pm_addr(pm_addr), .pm_data(pm_data),
        .rc_osc(rc_osc));

    // ==========================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] pm_exp(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction
    // fuse masks hold 1 for programmed, readback inverts
    function automatic logic [7:0] rb_exp(input int i);
        return (i == 0) ? ~f_lo : (i == 3) ? ~f_hi : (i == 2) ? ~f_ex : lock_rb;
    endfunction
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // request held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && k < 20)
        begin
            @(posedge clock);
            k++;
        end
        if (k >= 20)
            error_cnt++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never reassigns psel in this step
        @(posedge clock);
    endtask
    task automatic load(input logic [15:0] idx);
        int k;
        k = 0;
        load_req <= 1'b1;
        z_index <= idx;
        @(posedge clock);
        load_req <= 1'b0;
        @(posedge clock);
        while (load_result.valid !== 1'b1 && k < 6)
        begin
            @(posedge clock);
            k++;
        end
        if (k >= 6)
            error_cnt++;
        got = load_result.data;
    endtask
    task automatic store(input logic [7:0] d);
        store_req <= 1'b1;
        store_data <= d;
        z_index <= IDX_LOCK;
        @(posedge clock);
        store_req <= 1'b0;
        @(posedge clock);
    endtask

    // ==========================================
    // clock and watchdog
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial
    begin
        #(20000 * 8);
        error_cnt++;
        $display("watchdog expired");
        results;
    end

    // ==========================================
    // tests
    initial
    begin
        {rst_n, por_n, psel, penable, pwrite, load_req, store_req} = '0;
        {paddr, pwdata, z_index, store_data} = '0;
        error_cnt = 0;
        cmp_count = 0;
        lock_rb = 8'hFF;
        seed = lfsr(32'h26ADA9F1);
        {f_ex, f_hi, f_lo} = seed[23:0];
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (4) @(posedge clock);
        apb(ADDR_CTRL, 1'b0, 32'h0);
        chk("ctrl_reset", rd, {28'h0, CTRL_RESET});
        apb(8'h10, 1'b0, 32'h0);
        chk("unmapped_err", {31'h0, er}, 32'h1);
        $display("test registers done");
        // late loads fall back to an ordinary read once the window closes
        for (int i = 0; i < 16; i++)
        begin
            apb(ADDR_CTRL, 1'b1, 32'h9);
            repeat (i / 4) @(posedge clock);
            load(16'(i % 4));
            chk("readback", got, (i / 4 < 2) ? rb_exp(i % 4) : pm_exp(16'(i % 4)));
            apb(ADDR_CTRL, 1'b0, 32'h0);
            chk("ctrl_cleared", rd, 32'h0);
        end
        $display("test readback done");
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            apb(ADDR_CTRL, 1'b1, seed[16] ? 32'h8 : 32'h0);
            load(seed[15:0]);
            chk("pm_addr", pm_addr, seed[15:0]);
            chk("ordinary", got, pm_exp(seed[15:0]));
        end
        $display("test ordinary done");
        apb(ADDR_CTRL, 1'b1, 32'h1);
        // first cycle after the store window
        repeat (3) @(posedge clock);
        store(8'h00);
        chk("late_store", flash_busy, 1'b0);
        apb(ADDR_CTRL, 1'b0, 32'h0);
        chk("store_win_clear", rd, 32'h0);
        seed = lfsr(seed);
        apb(ADDR_CTRL, 1'b1, 32'h9);
        // last cycle of the store window
        repeat (2) @(posedge clock);
        store(seed[7:0]);
        chk("busy_start", flash_busy, 1'b1);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        chk("busy_thru_reset", flash_busy, 1'b1);
        ticks = 0;
        n = 0;
        rc_q = rc_osc;
        while (flash_busy === 1'b1 && n < 3000)
        begin
            @(posedge clock);
            n++;
            if (rc_osc && !rc_q)
                ticks++;
            rc_q = rc_osc;
        end
        if (n >= 3000)
            error_cnt++;
        // a rise caught in the sync lag at start counts only in the block
        chk("write_ticks", 32'(ticks >= WT - 1 && ticks <= WT), 32'h1);
        lock_rb = {2'b11, seed[5:2], 2'b11};
        repeat (4) @(posedge clock);
        apb(ADDR_CTRL, 1'b1, 32'h9);
        load(IDX_LOCK);
        chk("lock_after", got, lock_rb);
        $display("test flash write done");
        results;
    end
endmodule // fsrc_bench
`default_nettype wire
